// *** queued_flow_buffer_128q.sv ***
// Contract
// RULE1: Up to 128 queues share one memory.
// RULE2: One common 40-bit write and read bus.
// RULE3: Write words steered into selected write queue.
// RULE4: Read words taken from selected read queue.
// RULE5: Write and read sides operate independently.
// RULE6: Ports may select different or same queue.
// RULE7: Clock form handled outside; one rising edge.
// RULE8: Full for write queue, empty for read queue.
// RULE9: Per-queue almost flags on two 8-bit buses.
// RULE10: Eight queues direct, more time-multiplexed over lines.
// RULE11: Flag bus multiplexing polled or direct.
// RULE12: Ports 20 or 40 bits, order kept.
// RULE13: Spare bits pass through, no parity check.
// RULE14: Back-off-one switch leaves last word queued.
// RULE15: Standard switch delivers the last pipelined word.
// RULE16: Each port may mark its selected queue.
// RULE17: Return to mark drops or replays data.
// RULE18: Default after reset is 128 equal queues.
// RULE19: Master reset latches all configuration pins.
// RULE20: Single queue may use whole memory.
// RULE21: Almost flag offsets are programmable per queue.
// RULE22: Queue depth is whole 256-word blocks.
// RULE23: Selected queue stores words on enabled edges.
// RULE24: Full writes and empty reads are ignored.
`timescale 1ns/100ps
`default_nettype none
module queued_flow_buffer_128q (
   input wire logic mclk_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   input wire logic master_reset_n_i,
   input wire logic [2:0] cfg_queue_log_i,
   input wire logic cfg_wide_wr_i,
   input wire logic cfg_wide_rd_i,
   input wire logic back_off_one_select_i,
   input wire logic cfg_flag_polled_i,
   input wire logic prog_en_i,
   input wire logic [qfb_pkg::QW-1:0] prog_queue_i,
   input wire logic [qfb_pkg::CW-1:0] prog_af_offset_i,
   input wire logic [qfb_pkg::CW-1:0] prog_ae_offset_i,
   input wire logic wr_sel_en_i,
   input wire logic [qfb_pkg::QW-1:0] wr_sel_i,
   input wire logic wr_en_i,
   input wire logic [qfb_pkg::DATA_W-1:0] wr_data_i,
   input wire logic wr_mark_i,
   input wire logic wr_rewrite_i,
   input wire logic rd_sel_en_i,
   input wire logic [qfb_pkg::QW-1:0] rd_sel_i,
   input wire logic rd_en_i,
   input wire logic rd_mark_i,
   input wire logic rd_reread_i,
   input wire logic [qfb_pkg::GW-1:0] flag_group_sel_i,
   output logic [qfb_pkg::DATA_W-1:0] rd_data_o,
   output logic rd_valid_o,
   output logic write_queue_full_o,
   output logic read_queue_empty_o,
   output logic almost_full_flag_o,
   output logic almost_empty_flag_o,
   output logic [qfb_pkg::FLAG_BUS_W-1:0] almost_full_flag_bus_o,
   output logic [qfb_pkg::FLAG_BUS_W-1:0] almost_empty_flag_bus_o,
   output logic [qfb_pkg::GW-1:0] flag_bus_group_o
);
   import qfb_pkg::*;

   logic [1:0] rst_sync_q;
   logic rst_n;
   state_t s_q;
   state_t s_d;
   logic [AW-1:0] mask_q;
   logic [AW-1:0] mask_d;
   logic [AW-1:0] waddr;
   logic [AW-1:0] raddr;
   logic [AW-1:0] span;
   logic [DATA_W-1:0] wword;
   logic [DATA_W-1:0] ram_q;
   logic [GW-1:0] gmask;
   logic [NQ-1:0] af_vec;
   logic [NQ-1:0] ae_vec;
   logic push;
   logic pop;
   logic cancel;

   // The write queue's used words, counting the words held for replay and a word still in flight.
   function automatic logic is_full(input state_t s);
      logic [AW-1:0] m;
      logic [CW:0] used;
      m = PTR_ALL_ONES >> s.qlog;
      used = {1'b0, s.cnt[s.wq]};
      if (s.rmark_v && s.rq == s.wq)
         used = used + {2'b00, (s.rptr[s.wq] - s.rmark) & m};
      if (s.s1_v && s.s1_q == s.wq)
         used = used + 17'h00001;
      is_full = ((s.wq >> s.qlog) != '0) || (used >= {2'b00, m} + 17'h00001);
   endfunction: is_full

   always_ff @(posedge mclk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         rst_sync_q <= 2'h0;
      else
         rst_sync_q <= {rst_sync_q[0], 1'b1};
   end
   assign rst_n = rst_sync_q[1];

   // A queue is an aligned range of 32768 >> qlog words, so depth is always whole blocks.
   assign mask_q = PTR_ALL_ONES >> s_q.qlog; // RULE22 RULE1

   flow_storage u_storage (
      .mclk_i(mclk_i),
      .ce_i(ce_i),
      .wr_i(push),
      .waddr_i(waddr),
      .wdata_i(wword),
      .rd_i(pop),
      .raddr_i(raddr),
      .rdata_o(ram_q)
   );

   always_comb
   begin
      s_d = s_q;
      push = 1'b0;
      pop = 1'b0;
      cancel = 1'b0;
      span = '0;
      wword = wr_data_i;
      waddr = ({8'h00, s_q.wq} << (AW_SHIFT - {1'b0, s_q.qlog})) | s_q.wptr[s_q.wq]; // RULE3
      raddr = ({8'h00, s_q.rq} << (AW_SHIFT - {1'b0, s_q.qlog})) | s_q.rptr[s_q.rq]; // RULE4
      s_d.s1_v = 1'b0;
      s_d.s1h = 1'b0;
      s_d.rd_valid = 1'b0;
      if (!master_reset_n_i)
      begin
         // Configuration pins are sampled for as long as master reset is held.
         s_d = STATE_RESET; // RULE18
         s_d.qlog = cfg_queue_log_i; // RULE19 RULE20
         s_d.wide_wr = cfg_wide_wr_i;
         s_d.wide_rd = cfg_wide_rd_i;
         s_d.back_off_one_select = back_off_one_select_i;
         s_d.polled = cfg_flag_polled_i;
      end
      else
      begin
         if (prog_en_i)
         begin
            s_d.af_off[prog_queue_i] = prog_af_offset_i; // RULE21
            s_d.ae_off[prog_queue_i] = prog_ae_offset_i; // RULE21
         end
         // Write side acts on write-side pins; its full check also reads the read-side mark and in-flight word.
         if (wr_sel_en_i)
         begin
            s_d.wq = wr_sel_i; // RULE6
            s_d.wmark_v = 1'b0;
            s_d.half_v = 1'b0;
         end
         else if (wr_rewrite_i && s_q.wmark_v)
         begin
            // Words already read cannot be taken back, so the drop is capped by the count.
            span = (s_q.wptr[s_q.wq] - s_q.wmark) & mask_q;
            if ({1'b0, span} > s_q.cnt[s_q.wq])
               span = s_q.cnt[s_q.wq][AW-1:0];
            s_d.wptr[s_q.wq] = s_q.wmark; // RULE17
            s_d.cnt[s_q.wq] = s_d.cnt[s_q.wq] - {1'b0, span}; // RULE17
            s_d.half_v = 1'b0;
         end
         else
         begin
            if (wr_mark_i)
            begin
               s_d.wmark_v = 1'b1; // RULE16
               s_d.wmark = s_q.wptr[s_q.wq];
            end
            if (wr_en_i)
            begin
               if (!s_q.wide_wr && !s_q.half_v)
               begin
                  s_d.half_v = 1'b1;
                  s_d.half = wr_data_i[HALF_W-1:0];
               end
               else
               begin
                  // The first narrow half becomes the low half of the stored word.
                  wword = s_q.wide_wr ? wr_data_i : {wr_data_i[HALF_W-1:0], s_q.half}; // RULE12 RULE13
                  s_d.half_v = 1'b0;
                  push = !is_full(s_q); // RULE24 RULE23
               end
            end
         end
         if (push)
         begin
            s_d.wptr[s_q.wq] = (s_q.wptr[s_q.wq] + 15'h0001) & mask_q;
            s_d.cnt[s_q.wq] = s_d.cnt[s_q.wq] + 16'h0001;
         end
         // Read side.
         if (rd_sel_en_i)
         begin
            // With back-off-one selected, the in-flight word is handed back to its queue instead of being shown.
            cancel = s_q.back_off_one_select && s_q.s1_v; // RULE14
            s_d.rq = rd_sel_i; // RULE6
            s_d.rmark_v = 1'b0;
            s_d.hi_owed = 1'b0;
         end
         else if (rd_reread_i && s_q.rmark_v)
         begin
            span = (s_q.rptr[s_q.rq] - s_q.rmark) & mask_q;
            s_d.rptr[s_q.rq] = s_q.rmark; // RULE17
            s_d.cnt[s_q.rq] = s_d.cnt[s_q.rq] + {1'b0, span}; // RULE17
            s_d.hi_owed = 1'b0;
         end
         else
         begin
            if (rd_mark_i)
            begin
               s_d.rmark_v = 1'b1; // RULE16
               s_d.rmark = s_q.rptr[s_q.rq];
            end
            if (rd_en_i)
            begin
               if (s_q.hi_owed)
               begin
                  s_d.s1h = 1'b1; // RULE12
                  s_d.hi_owed = 1'b0;
               end
               else if ((s_q.rq >> s_q.qlog) == '0 && s_q.cnt[s_q.rq] != '0) // RULE24
               begin
                  pop = 1'b1;
                  s_d.rptr[s_q.rq] = (s_q.rptr[s_q.rq] + 15'h0001) & mask_q;
                  s_d.cnt[s_q.rq] = s_d.cnt[s_q.rq] - 16'h0001;
                  s_d.s1_v = 1'b1;
                  s_d.s1_q = s_q.rq;
                  s_d.hi_owed = !s_q.wide_rd;
               end
            end
         end
         if (cancel)
         begin
            s_d.rptr[s_q.s1_q] = (s_q.rptr[s_q.s1_q] - 15'h0001) & mask_q; // RULE14
            s_d.cnt[s_q.s1_q] = s_d.cnt[s_q.s1_q] + 16'h0001;
         end
         // Without back-off-one the fetched word reaches the port even across a switch.
         if (s_q.s1_v && !cancel) // RULE15
         begin
            s_d.rd_valid = 1'b1;
            s_d.rd_data = s_q.wide_rd ? ram_q : {{HALF_W{1'b0}}, ram_q[HALF_W-1:0]};
            s_d.hold = ram_q[DATA_W-1:HALF_W];
         end
         else if (s_q.s1h)
         begin
            s_d.rd_valid = 1'b1;
            s_d.rd_data = {{HALF_W{1'b0}}, s_q.hold}; // RULE12
         end
      end
      mask_d = PTR_ALL_ONES >> s_d.qlog;
      for (int i = 0; i < NQ; i++)
      begin
         af_vec[i] = ((QW'(i) >> s_d.qlog) == '0) &&
            ({1'b0, s_d.cnt[i]} + {1'b0, s_d.af_off[i]} >= {2'b00, mask_d} + 17'h00001); // RULE9
         af_vec[i] = af_vec[i] && ((QW'(i) >> s_d.qlog) == '0);
         ae_vec[i] = ((QW'(i) >> s_d.qlog) == '0) && (s_d.cnt[i] <= s_d.ae_off[i]); // RULE9
      end
      gmask = (s_d.qlog > FLAG_BUS_LOG) ? (GROUP_ALL_ONES >> (3'h7 - s_d.qlog)) : '0;
      if (!s_d.polled)
         s_d.group = flag_group_sel_i & gmask; // RULE11
      else if (master_reset_n_i)
         s_d.group = (s_q.group + 4'h1) & gmask; // RULE10 RULE11
      s_d.af_bus = af_vec[{s_d.group, 3'h0} +: FLAG_BUS_W]; // RULE10
      s_d.ae_bus = ae_vec[{s_d.group, 3'h0} +: FLAG_BUS_W]; // RULE10
      s_d.full = is_full(s_d); // RULE8
      s_d.empty = ((s_d.rq >> s_d.qlog) != '0) || (s_d.cnt[s_d.rq] == '0); // RULE8
      s_d.af = af_vec[s_d.wq];
      s_d.ae = ae_vec[s_d.rq];
   end

   // Both ports sample on the rising edge of the one clock, each by its own enables.
   always_ff @(posedge mclk_i or negedge rst_n) // RULE7 RULE5
   begin
      if (!rst_n)
         s_q <= STATE_RESET;
      else if (ce_i)
         s_q <= s_d;
   end

   assign rd_data_o = s_q.rd_data; // RULE2
   assign rd_valid_o = s_q.rd_valid;
   assign write_queue_full_o = s_q.full;
   assign read_queue_empty_o = s_q.empty;
   assign almost_full_flag_o = s_q.af;
   assign almost_empty_flag_o = s_q.ae;
   assign almost_full_flag_bus_o = s_q.af_bus;
   assign almost_empty_flag_bus_o = s_q.ae_bus;
   assign flag_bus_group_o = s_q.group;

   logic [CW-1:0] cnt_wq;
   logic [CW-1:0] cnt_rq;
   assign cnt_wq = s_q.cnt[s_q.wq];
   assign cnt_rq = s_q.cnt[s_q.rq];

   empty_read_ignored_a: assert property (@(posedge mclk_i) disable iff (!rst_n) // RULE24
      (ce_i && master_reset_n_i && rd_en_i && !rd_sel_en_i && cnt_rq == '0 && !s_q.hi_owed)
      ##1 ce_i |=> !rd_valid_o)
      else $error("read from empty queue produced data");
   read_latency_a: assert property (@(posedge mclk_i) disable iff (!rst_n) // RULE4
      (ce_i && pop) ##1 (ce_i && !cancel && master_reset_n_i) |=> rd_valid_o)
      else $error("accepted read did not deliver data two edges later");
   full_write_ignored_a: assert property (@(posedge mclk_i) disable iff (!rst_n) // RULE24
      ce_i && master_reset_n_i && wr_en_i && is_full(s_q) && !wr_sel_en_i && !rd_reread_i
      && !cancel |=> cnt_wq <= $past(cnt_wq))
      else $error("write to full queue raised its count");
   count_bound_a: assert property (@(posedge mclk_i) disable iff (!rst_n) // RULE22
      cnt_wq <= {1'b0, mask_q} + 16'h0001)
      else $error("queue count exceeds queue depth");
   boi_cancel_a: assert property (@(posedge mclk_i) disable iff (!rst_n) // RULE14
      ce_i && cancel |=> !rd_valid_o && s_q.cnt[$past(s_q.s1_q)] != '0)
      else $error("back-off-one switch still delivered the word");
   std_delivery_a: assert property (@(posedge mclk_i) disable iff (!rst_n) // RULE15
      ce_i && master_reset_n_i && s_q.s1_v && !s_q.back_off_one_select |=> rd_valid_o)
      else $error("standard mode dropped a pipelined word");
   reread_restore_a: assert property (@(posedge mclk_i) disable iff (!rst_n) // RULE17
      ce_i && master_reset_n_i && rd_reread_i && s_q.rmark_v && !rd_sel_en_i && !cancel
      |=> s_q.rptr[s_q.rq] == $past(s_q.rmark))
      else $error("re-read did not return to the mark");
   polled_group_a: assert property (@(posedge mclk_i) disable iff (!rst_n) // RULE10
      ce_i && master_reset_n_i && s_q.polled && s_q.qlog > FLAG_BUS_LOG
      |=> flag_bus_group_o != $past(flag_bus_group_o))
      else $error("polled flag bus did not advance");
   empty_flag_a: assert property (@(posedge mclk_i) disable iff (!rst_n) // RULE8
      read_queue_empty_o == (((s_q.rq >> s_q.qlog) != '0) || cnt_rq == '0))
      else $error("empty flag disagrees with selected queue");
endmodule: queued_flow_buffer_128q
`default_nettype wire

// *** qfb_pkg.sv ***
`default_nettype none
package qfb_pkg;
   localparam int NQ = 128;
   localparam int QW = 7;
   localparam int BLOCK_WORDS = 256;
   localparam int TOTAL_BLOCKS = 128;
   localparam int MEM_WORDS = BLOCK_WORDS * TOTAL_BLOCKS;
   localparam int AW = 15;
   localparam int CW = 16;
   localparam int DATA_W = 40;
   localparam int HALF_W = 20;
   localparam int FLAG_BUS_W = 8;
   localparam int GW = 4;
   localparam logic [2:0] DEFAULT_QUEUE_LOG = 3'h7;
   localparam logic [2:0] FLAG_BUS_LOG = 3'h3;
   localparam logic [3:0] AW_SHIFT = 4'hf;
   localparam logic [AW-1:0] PTR_ALL_ONES = 15'h7fff;
   localparam logic [GW-1:0] GROUP_ALL_ONES = 4'hf;
   localparam logic [CW-1:0] DEFAULT_AF_OFFSET = 16'h0008;
   localparam logic [CW-1:0] DEFAULT_AE_OFFSET = 16'h0008;

   typedef struct packed {
      logic [2:0] qlog;
      logic wide_wr;
      logic wide_rd;
      logic back_off_one_select;
      logic polled;
      logic [NQ-1:0][AW-1:0] wptr;
      logic [NQ-1:0][AW-1:0] rptr;
      logic [NQ-1:0][CW-1:0] cnt;
      logic [NQ-1:0][CW-1:0] af_off;
      logic [NQ-1:0][CW-1:0] ae_off;
      logic [QW-1:0] wq;
      logic [QW-1:0] rq;
      logic wmark_v;
      logic [AW-1:0] wmark;
      logic rmark_v;
      logic [AW-1:0] rmark;
      logic half_v;
      logic [HALF_W-1:0] half;
      logic hi_owed;
      logic [HALF_W-1:0] hold;
      logic s1_v;
      logic [QW-1:0] s1_q;
      logic s1h;
      logic [GW-1:0] group;
      logic [DATA_W-1:0] rd_data;
      logic rd_valid;
      logic full;
      logic empty;
      logic af;
      logic ae;
      logic [FLAG_BUS_W-1:0] af_bus;
      logic [FLAG_BUS_W-1:0] ae_bus;
   } state_t;

   localparam state_t STATE_RESET = '{qlog: DEFAULT_QUEUE_LOG, wide_wr: 1'b1, wide_rd: 1'b1,
      af_off: {NQ{DEFAULT_AF_OFFSET}}, ae_off: {NQ{DEFAULT_AE_OFFSET}}, empty: 1'b1,
      default: '0};
endpackage: qfb_pkg
`default_nettype wire

// *** flow_storage.sv ***
`timescale 1ns/100ps
`default_nettype none
module flow_storage (
   input wire logic mclk_i,
   input wire logic ce_i,
   input wire logic wr_i,
   input wire logic [qfb_pkg::AW-1:0] waddr_i,
   input wire logic [qfb_pkg::DATA_W-1:0] wdata_i,
   input wire logic rd_i,
   input wire logic [qfb_pkg::AW-1:0] raddr_i,
   output logic [qfb_pkg::DATA_W-1:0] rdata_o
);
   import qfb_pkg::*;

   // One array holds every queue; queues are address ranges within it.
   logic [DATA_W-1:0] mem [MEM_WORDS];

   always_ff @(posedge mclk_i)
   begin
      if (ce_i)
      begin
         if (wr_i)
            mem[waddr_i] <= wdata_i;
         if (rd_i)
            rdata_o <= mem[raddr_i];
      end
   end
endmodule: flow_storage
`default_nettype wire

// *** frame_sink.sv ***
`timescale 1ns/100ps
`default_nettype none
module frame_sink (
   input wire logic mclk_i,
   input wire logic rd_valid_i,
   input wire logic [qfb_pkg::DATA_W-1:0] rd_data_i
);
   import qfb_pkg::*;
   // Only a clean high strobe is taken, so an unknown never passes as a delivered word.
   logic [DATA_W-1:0] got [$];
   always @(posedge mclk_i)
   begin
      if (rd_valid_i === 1'b1)
      begin
         got.push_back(rd_data_i);
      end
   end
endmodule: frame_sink
`default_nettype wire

// *** tb_queued_flow_buffer_128q.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_queued_flow_buffer_128q;
   import qfb_pkg::*;
   logic mclk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic mrst_n = 1'b1, wide_wr = 1'b1, wide_rd = 1'b1, back_off_one_select = 1'b0, polled = 1'b0;
   logic prog_en = 1'b0;
   logic [2:0] qlog = 3'h7;
   logic [QW-1:0] prog_q = '0, wr_sel = '0, rd_sel = '0;
   logic [CW-1:0] prog_af = 16'h0008, prog_ae = 16'h0008;
   logic wr_sel_en = 1'b0, wr_en = 1'b0, wr_mark = 1'b0, wr_rewrite = 1'b0;
   logic rd_sel_en = 1'b0, rd_en = 1'b0, rd_mark = 1'b0, rd_reread = 1'b0;
   logic [DATA_W-1:0] wr_data = '0, rd_data;
   logic [GW-1:0] grp_sel = '0, grp, g;
   logic rd_valid, wfull, rempty, af, ae;
   logic [FLAG_BUS_W-1:0] af_bus, ae_bus;
   int mismatches = 0;
   int n_compared = 0;
   int depth = 256, wq = 0, rq = 0, wmark_n = 0, owe = 0;
   logic [DATA_W-1:0] hi_w = '0;
   logic [31:0] seed = 32'h00000052;
   logic [DATA_W-1:0] mq [NQ][$];
   logic [DATA_W-1:0] exp_q [$], rmark_q [$];

   queued_flow_buffer_128q queued_flow_buffer_128q_i (.mclk_i(mclk_i), .resetn_i(resetn_i),
      .ce_i(1'b1), .master_reset_n_i(mrst_n), .cfg_queue_log_i(qlog), .cfg_wide_wr_i(wide_wr),
      .cfg_wide_rd_i(wide_rd), .back_off_one_select_i(back_off_one_select), .cfg_flag_polled_i(polled),
      .prog_en_i(prog_en), .prog_queue_i(prog_q), .prog_af_offset_i(prog_af),
      .prog_ae_offset_i(prog_ae), .wr_sel_en_i(wr_sel_en), .wr_sel_i(wr_sel),
      .wr_en_i(wr_en), .wr_data_i(wr_data), .wr_mark_i(wr_mark), .wr_rewrite_i(wr_rewrite),
      .rd_sel_en_i(rd_sel_en), .rd_sel_i(rd_sel), .rd_en_i(rd_en), .rd_mark_i(rd_mark),
      .rd_reread_i(rd_reread), .flag_group_sel_i(grp_sel), .rd_data_o(rd_data),
      .rd_valid_o(rd_valid), .write_queue_full_o(wfull), .read_queue_empty_o(rempty),
      .almost_full_flag_o(af), .almost_empty_flag_o(ae), .almost_full_flag_bus_o(af_bus),
      .almost_empty_flag_bus_o(ae_bus), .flag_bus_group_o(grp));
   frame_sink frame_sink_i (.mclk_i(mclk_i), .rd_valid_i(rd_valid), .rd_data_i(rd_data));

   initial
   begin
      forever #2 mclk_i = ~mclk_i;
   end

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction: rnd

   task automatic stop_test();
      if (mismatches == 0 && n_compared > 0)
      begin
         $display("ALL TESTS PASSED");
      end
      else
      begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask: stop_test

   task automatic chk_word(input string name, input logic [63:0] e, input logic [63:0] s);
      n_compared++;
      if (s !== e)
      begin
         mismatches++;
         $display("CHECK FAILED %s expected %0h seen %0h", name, e, s);
      end
   endtask: chk_word

   task automatic chk_flag(input string name, input logic e);
      @(negedge mclk_i);
      chk_word(name, {63'h0, e}, {63'h0, (name == "full") ? wfull : (name == "empty") ? rempty
         : (name == "af") ? af : (name == "ae") ? ae : af_bus[5]});
   endtask: chk_flag

   task automatic mrst(input logic [2:0] q3, input logic ww, input logic wrd, input logic b,
      input logic p);
      @(posedge mclk_i);
      {qlog, wide_wr, wide_rd, back_off_one_select, polled, mrst_n} <= {q3, ww, wrd, b, p, 1'b0};
      @(posedge mclk_i);
      @(posedge mclk_i);
      mrst_n <= 1'b1;
      @(posedge mclk_i);
      foreach (mq[i]) mq[i].delete();
      depth = 32768 >> q3;
   endtask: mrst

   task automatic sel(input bit rd, input int q);
      @(posedge mclk_i);
      if (rd)
      begin
         {rd_sel_en, rd_sel} <= {1'b1, q[QW-1:0]};
         rq = q;
         owe = 0;
      end
      else
      begin
         {wr_sel_en, wr_sel} <= {1'b1, q[QW-1:0]};
         wq = q;
      end
      @(posedge mclk_i);
      {rd_sel_en, wr_sel_en} <= 2'b00;
   endtask: sel

   task automatic wr_burst(input int n);
      logic [DATA_W-1:0] d;
      logic [31:0] t;
      for (int i = 0; i < n; i++)
      begin
         t = rnd();
         d = {t[7:0], rnd()};
         @(posedge mclk_i);
         wr_en <= 1'b1;
         wr_data <= d;
         if (!wide_wr)
         begin
            @(posedge mclk_i);
            wr_data <= {d[19:0], d[39:20]};
         end
         if (mq[wq].size() < depth) mq[wq].push_back(d);
      end
      @(posedge mclk_i);
      wr_en <= 1'b0;
   endtask: wr_burst

   task automatic rd_burst(input int n);
      for (int i = 0; i < n; i++)
      begin
         @(posedge mclk_i);
         rd_en <= 1'b1;
         if (wide_rd && mq[rq].size() > 0) exp_q.push_back(mq[rq].pop_front());
         else if (!wide_rd && owe != 0)
         begin
            exp_q.push_back({20'h0, hi_w[39:20]});
            owe = 0;
         end
         else if (!wide_rd && mq[rq].size() > 0)
         begin
            hi_w = mq[rq].pop_front();
            exp_q.push_back({20'h0, hi_w[19:0]});
            owe = 1;
         end
      end
      @(posedge mclk_i);
      rd_en <= 1'b0;
   endtask: rd_burst

   task automatic drain();
      repeat (4) @(posedge mclk_i);
      chk_word("rd_count", exp_q.size(), frame_sink_i.got.size());
      while (exp_q.size() > 0 && frame_sink_i.got.size() > 0)
         chk_word("rd_data", exp_q.pop_front(), frame_sink_i.got.pop_front());
      exp_q.delete();
      frame_sink_i.got.delete();
   endtask: drain

   task automatic ctl(input logic [3:0] v);
      @(posedge mclk_i);
      {wr_mark, wr_rewrite, rd_mark, rd_reread} <= v;
      if (v[3]) wmark_n = mq[wq].size();
      if (v[2]) while (mq[wq].size() > wmark_n) void'(mq[wq].pop_back());
      if (v[1]) rmark_q = mq[rq];
      if (v[0])
      begin
         mq[rq] = rmark_q;
         owe = 0;
      end
      @(posedge mclk_i);
      {wr_mark, wr_rewrite, rd_mark, rd_reread} <= 4'h0;
   endtask: ctl

   // One read, then a queue select in the very next cycle: back-off-one keeps the word.
   task automatic rd_switch(input int q, input int other);
      sel(1, q);
      @(posedge mclk_i);
      rd_en <= 1'b1;
      @(posedge mclk_i);
      {rd_en, rd_sel_en, rd_sel} <= {1'b0, 1'b1, other[QW-1:0]};
      if (!back_off_one_select) exp_q.push_back(mq[q].pop_front());
      @(posedge mclk_i);
      rd_sel_en <= 1'b0;
      drain();
   endtask: rd_switch

   initial
   begin
      // The whole sequence needs about 700 cycles; this limit sits well beyond it.
      #40000;
      mismatches++;
      stop_test();
   end

   initial
   begin
      repeat (6) @(posedge mclk_i);
      resetn_i <= 1'b1;
      repeat (3) @(posedge mclk_i);
      chk_flag("empty", 1'b1);
      chk_flag("full", 1'b0);
      mrst(3'h7, 1'b1, 1'b1, 1'b0, 1'b0);
      sel(0, 3);
      wr_burst(5);
      sel(0, 100);
      wr_burst(4);
      rd_switch(3, 9);
      sel(1, 100);
      rd_burst(4);
      drain();
      sel(1, 3);
      rd_burst(6);
      drain();
      chk_flag("empty", 1'b1);
      sel(0, 7);
      wr_burst(2);
      ctl(4'h8);
      wr_burst(3);
      ctl(4'h4);
      sel(1, 7);
      ctl(4'h2);
      rd_burst(2);
      drain();
      ctl(4'h1);
      rd_burst(3);
      drain();
      @(posedge mclk_i);
      {prog_en, prog_q, prog_af, prog_ae} <= {1'b1, 7'h05, 16'h0010, 16'h0010};
      @(posedge mclk_i);
      prog_en <= 1'b0;
      sel(0, 5);
      sel(1, 5);
      wr_burst(depth - 17);
      chk_flag("af", 1'b0);
      wr_burst(1);
      chk_flag("af", 1'b1);
      wr_burst(15);
      chk_flag("full", 1'b0);
      wr_burst(2);
      chk_flag("full", 1'b1);
      repeat (3) @(posedge mclk_i);
      chk_flag("af_bus5", 1'b1);
      chk_flag("ae", 1'b0);
      rd_burst(depth);
      drain();
      chk_flag("ae", 1'b1);
      @(posedge mclk_i);
      grp_sel <= 4'h6;
      repeat (2) @(posedge mclk_i);
      @(negedge mclk_i);
      chk_word("group", 64'h6, {60'h0, grp});
      mrst(3'h7, 1'b1, 1'b1, 1'b0, 1'b1);
      @(negedge mclk_i);
      g = grp + 4'h1;
      @(negedge mclk_i);
      chk_word("group_step", {60'h0, g}, {60'h0, grp});
      mrst(3'h3, 1'b0, 1'b0, 1'b1, 1'b0);
      repeat (2) @(posedge mclk_i);
      @(negedge mclk_i);
      chk_word("group_8q", 64'h0, {60'h0, grp});
      sel(0, 2);
      wr_burst(2);
      rd_switch(2, 3);
      sel(1, 2);
      rd_burst(2);
      drain();
      stop_test();
   end
endmodule: tb_queued_flow_buffer_128q
`default_nettype wire
